// *** design/svi_irq_ctrl.sv ***
// Purpose: Receiver interrupt status, clear, pin enable and pin pulse
// Assumes: Event inputs are on ref_clk; bus pins are asynchronous
// Notes:   Bus slave is a minimal two-wire target, no clock stretching
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Keep-masked set: status captures triggered events even with enable off.
// - Events captured with enable off are readable but reach the pin only once their enable is set.
// - Status holds until its clear; only then may the source interrupt again.
// - Keep-masked clear: events with enable off are not retained.
// - Pin length code: 4, 16, 64 crystal periods, or held until cleared.
// - Cable sense clear bit clears its status.
// - Link PLL lock clear bit clears its status.
// - Link clock sense clear bit clears its status.
// - Stereo video clear bit clears its status.
// - AV silence clear bit clears its status.
// - Link mode clear bit clears its status.
// - General control and gamut packet clear bits clear their own status.
// - Recording code and frame clear bits each clear only their own status.
// - Writing zero to a clear bit changes nothing.
// - Level enables in the first enable register route events to the pin.
// - Packet and frame enables route their events to the pin.
// - An enable at zero keeps its event off the pin.
// - Frame checksum error clear bits clear their edge status.
// - Colour depth and link clock change clears clear their edge status.
// - Packet fault edge clear bit clears its status.
// - Gamut edge clear bit clears its status.
module svi_irq_ctrl
  import svi_pkg::*;
#(
  parameter logic [6:0]  DEV_ADDR = 7'h4c,
  parameter int unsigned XTAL_DIV = 1
) (
  input  wire logic          ref_clk,
  input  wire logic          rst_n,
  input  wire logic          scl_in,
  input  wire logic          sda_in,
  output logic               sda_out,
  output logic               sda_oe_n,
  input  wire svi_lvl_evt_s  lvl_evt,
  input  wire svi_edge_evt_s edge_evt,
  output svi_lvl_evt_s       lvl_status,
  output svi_edge_evt_s      edge_status,
  output logic               second_irq_pin
);

  if (XTAL_DIV < 1 || XTAL_DIV > 1024) begin : g_chk
    $error("svi_irq_ctrl XTAL_DIV must lie in 1..1024");
  end

  localparam int unsigned CNT_SHORT = PULSE_XTAL_SHORT * XTAL_DIV;
  localparam int unsigned CNT_MID   = PULSE_XTAL_MID * XTAL_DIV;
  localparam int unsigned CNT_LONG  = PULSE_XTAL_LONG * XTAL_DIV;
  localparam int unsigned CNT_W     = $clog2(CNT_LONG + 1);

  // Pin synchronisers
  logic            scl_m_ff;
  logic            scl_s_ff;
  logic            scl_d_ff;
  logic            sda_m_ff;
  logic            sda_s_ff;
  logic            sda_d_ff;

  // Bus target state
  svi_bus_state_e  state_ff;
  svi_bus_state_e  nxt_state;
  logic [3:0]      bit_cnt_ff;
  logic [3:0]      nxt_bit_cnt;
  logic [1:0]      byte_idx_ff;
  logic [1:0]      nxt_byte_idx;
  logic [7:0]      shreg_ff;
  logic [7:0]      nxt_shreg;
  logic            rw_ff;
  logic            nxt_rw;
  logic [15:0]     addr_ff;
  logic [15:0]     nxt_addr;
  logic            sda_oe_n_ff;
  logic            nxt_sda_oe_n;
  logic            wr_stb;

  // Registers
  logic            keep_ff;
  logic [1:0]      dur_ff;
  logic [LVL_N-1:0] lvl_en_ff;
  logic [7:0]      rd_data;

  // Pin pulse
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic [CNT_W-1:0] pulse_len;
  logic [LVL_N-1:0] pin_src_d_ff;
  logic             pin_ff;
  logic             nxt_pin;

  // Bus conditions
  wire scl_rise = scl_s_ff & ~scl_d_ff;
  wire scl_fall = ~scl_s_ff & scl_d_ff;
  wire bus_start = scl_s_ff & scl_d_ff & sda_d_ff & ~sda_s_ff;
  wire bus_stop  = scl_s_ff & scl_d_ff & ~sda_d_ff & sda_s_ff;
  wire addr_hit  = (shreg_ff[7:1] == DEV_ADDR);

  // Write decode
  wire wr_cfg    = wr_stb && (addr_ff == OFS_CAPTURE_CFG);
  wire wr_clr_la = wr_stb && (addr_ff == OFS_LVL_CLR_A);
  wire wr_clr_lb = wr_stb && (addr_ff == OFS_LVL_CLR_B);
  wire wr_en_a   = wr_stb && (addr_ff == OFS_LVL_PIN2_A);
  wire wr_en_b   = wr_stb && (addr_ff == OFS_LVL_PIN2_B);
  wire wr_clr_ea = wr_stb && (addr_ff == OFS_EDGE_CLR_A);
  wire wr_clr_eb = wr_stb && (addr_ff == OFS_EDGE_CLR_B);

  // Clear strobes last one cycle and are never stored
  wire [5:0] clr_la = wr_clr_la ? shreg_ff[LVL_A_MSB:0] : 6'h00;
  wire [7:0] clr_lb = wr_clr_lb ? shreg_ff : 8'h00;
  wire [5:0] clr_ea = wr_clr_ea ? shreg_ff[EDGE_A_MSB:0] : 6'h00;
  wire [1:0] clr_eb = wr_clr_eb ? shreg_ff[7:EDGE_B_LSB] : 2'h0;

  // Only ones in the written byte clear anything
  wire [LVL_N-1:0]  lvl_clr  = {clr_la, clr_lb};
  wire [EDGE_N-1:0] edge_clr = {clr_ea, clr_eb};

  // Capture when enabled, or always when keep-masked is set
  wire [LVL_N-1:0]  lvl_cap  = lvl_en_ff | {LVL_N{keep_ff}};
  wire [LVL_N-1:0]  lvl_stat_v;
  wire [EDGE_N-1:0] edge_stat_v;

  // Masked status reaches the pin, unmasked never does
  wire [LVL_N-1:0]  pin_src = lvl_stat_v & lvl_en_ff;
  wire              pin_new = |(pin_src & ~pin_src_d_ff);
  wire              pin_any = |pin_src;

  // Read decode
  wire rd_cfg  = (addr_ff == OFS_CAPTURE_CFG);
  wire rd_en_a = (addr_ff == OFS_LVL_PIN2_A);
  wire rd_en_b = (addr_ff == OFS_LVL_PIN2_B);
  wire [7:0] rd_cfg_v  = {5'h00, keep_ff, dur_ff};
  wire [7:0] rd_en_a_v = {2'h0, lvl_en_ff[LVL_N-1:8]};
  wire [7:0] rd_en_b_v = lvl_en_ff[7:0];

  // Clear registers and unmapped offsets read zero
  assign rd_data = rd_cfg  ? rd_cfg_v  :
                   rd_en_a ? rd_en_a_v :
                   rd_en_b ? rd_en_b_v : RST_READ_ZERO;

  svi_status_cell #(
    .WIDTH (LVL_N)
  ) u_lvl_cell (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .src     (lvl_evt),
    .clr     (lvl_clr),
    .cap_en  (lvl_cap),
    .status  (lvl_stat_v)
  );

  // Edge events have no enable here, so they always capture
  svi_status_cell #(
    .WIDTH (EDGE_N)
  ) u_edge_cell (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .src     (edge_evt),
    .clr     (edge_clr),
    .cap_en  ({EDGE_N{1'b1}}),
    .status  (edge_stat_v)
  );

  assign lvl_status     = lvl_stat_v;
  assign edge_status    = edge_stat_v;
  assign sda_out        = 1'b0;
  assign sda_oe_n       = sda_oe_n_ff;
  assign second_irq_pin = pin_ff;

  // Bus target sequencing
  always_comb begin
    nxt_state    = state_ff;
    nxt_bit_cnt  = bit_cnt_ff;
    nxt_byte_idx = byte_idx_ff;
    nxt_shreg    = shreg_ff;
    nxt_rw       = rw_ff;
    nxt_addr     = addr_ff;
    nxt_sda_oe_n = sda_oe_n_ff;
    wr_stb       = 1'b0;
    if (bus_stop) begin
      nxt_state    = SVI_ST_IDLE;
      nxt_sda_oe_n = 1'b1;
    end else if (bus_start) begin
      nxt_state    = SVI_ST_RX;
      nxt_bit_cnt  = 4'h0;
      nxt_byte_idx = 2'h0;
      nxt_sda_oe_n = 1'b1;
    end else begin
      case (state_ff)
        SVI_ST_IDLE: begin
          nxt_sda_oe_n = 1'b1;
        end
        SVI_ST_RX: begin
          if (scl_rise && bit_cnt_ff != 4'h8) begin
            nxt_shreg   = {shreg_ff[6:0], sda_s_ff};
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
          end else if (scl_fall && bit_cnt_ff == 4'h8) begin
            nxt_bit_cnt = 4'h0;
            if (byte_idx_ff != 2'h3) begin
              nxt_byte_idx = byte_idx_ff + 2'h1;
            end
            if (byte_idx_ff == 2'h0 && !addr_hit) begin
              // Not our address, stay off the bus until the next start
              nxt_state = SVI_ST_IDLE;
            end else begin
              nxt_state    = SVI_ST_RX_ACK;
              nxt_sda_oe_n = 1'b0;
            end
            case (byte_idx_ff)
              2'h0: nxt_rw = shreg_ff[0];
              2'h1: nxt_addr = {shreg_ff, addr_ff[7:0]};
              2'h2: nxt_addr = {addr_ff[15:8], shreg_ff};
              default: begin
                // Step only after data, the strobe still sees the old offset
                wr_stb   = 1'b1;
                nxt_addr = addr_ff + 16'h0001;
              end
            endcase
          end
        end
        SVI_ST_RX_ACK: begin
          if (scl_fall) begin
            if (rw_ff && byte_idx_ff == 2'h1) begin
              nxt_state    = SVI_ST_TX;
              nxt_shreg    = rd_data;
              nxt_sda_oe_n = rd_data[7];
            end else begin
              nxt_state    = SVI_ST_RX;
              nxt_sda_oe_n = 1'b1;
            end
          end
        end
        SVI_ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_ff == 4'h7) begin
              nxt_state    = SVI_ST_TX_ACK;
              nxt_bit_cnt  = 4'h0;
              nxt_sda_oe_n = 1'b1;
            end else begin
              nxt_shreg    = {shreg_ff[6:0], 1'b0};
              nxt_sda_oe_n = shreg_ff[6];
              nxt_bit_cnt  = bit_cnt_ff + 4'h1;
            end
          end
        end
        SVI_ST_TX_ACK: begin
          if (scl_rise) begin
            if (sda_s_ff) begin
              nxt_state = SVI_ST_IDLE;
            end else begin
              nxt_addr = addr_ff + 16'h0001;
            end
          end else if (scl_fall) begin
            nxt_state    = SVI_ST_TX;
            nxt_shreg    = rd_data;
            nxt_sda_oe_n = rd_data[7];
          end
        end
        default: begin
          nxt_state    = SVI_ST_IDLE;
          nxt_sda_oe_n = 1'b1;
        end
      endcase
    end
  end

  // Pulse length from the two-bit code
  always_comb begin
    case (svi_dur_e'(dur_ff))
      SVI_DUR_SHORT: pulse_len = CNT_W'(CNT_SHORT);
      SVI_DUR_MID:   pulse_len = CNT_W'(CNT_MID);
      SVI_DUR_LONG:  pulse_len = CNT_W'(CNT_LONG);
      default:       pulse_len = CNT_W'(CNT_SHORT);
    endcase
  end

  // A new masked event restarts the pulse
  assign nxt_cnt = pin_new ? pulse_len :
                   (cnt_ff != '0) ? cnt_ff - CNT_W'(1) : '0;

  // Hold mode follows the masked status until software clears it
  assign nxt_pin = (dur_ff == SVI_DUR_HOLD) ? pin_any : (nxt_cnt != '0);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      scl_m_ff <= 1'b1;
      scl_s_ff <= 1'b1;
      scl_d_ff <= 1'b1;
      sda_m_ff <= 1'b1;
      sda_s_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_m_ff <= scl_in;
      scl_s_ff <= scl_m_ff;
      scl_d_ff <= scl_s_ff;
      sda_m_ff <= sda_in;
      sda_s_ff <= sda_m_ff;
      sda_d_ff <= sda_s_ff;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_ff    <= SVI_ST_IDLE;
      bit_cnt_ff  <= 4'h0;
      byte_idx_ff <= 2'h0;
      shreg_ff    <= 8'h00;
      rw_ff       <= 1'b0;
      addr_ff     <= 16'h0000;
      sda_oe_n_ff <= 1'b1;
    end else begin
      state_ff    <= nxt_state;
      bit_cnt_ff  <= nxt_bit_cnt;
      byte_idx_ff <= nxt_byte_idx;
      shreg_ff    <= nxt_shreg;
      rw_ff       <= nxt_rw;
      addr_ff     <= nxt_addr;
      sda_oe_n_ff <= nxt_sda_oe_n;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      keep_ff <= RST_CAPTURE_CFG[CFG_KEEP_BIT];
      dur_ff  <= RST_CAPTURE_CFG[CFG_DUR_LSB +: 2];
    end else if (wr_cfg) begin
      keep_ff <= shreg_ff[CFG_KEEP_BIT];
      dur_ff  <= shreg_ff[CFG_DUR_LSB +: 2];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      lvl_en_ff <= {RST_LVL_PIN2_A[LVL_A_MSB:0], RST_LVL_PIN2_B};
    end else begin
      if (wr_en_a) begin
        lvl_en_ff[LVL_N-1:8] <= shreg_ff[LVL_A_MSB:0];
      end
      if (wr_en_b) begin
        lvl_en_ff[7:0] <= shreg_ff;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt_ff       <= '0;
      pin_src_d_ff <= '0;
      pin_ff       <= 1'b0;
    end else begin
      cnt_ff       <= nxt_cnt;
      pin_src_d_ff <= pin_src;
      pin_ff       <= nxt_pin;
    end
  end

endmodule : svi_irq_ctrl
`default_nettype wire

// *** design/svi_pkg.sv ***
// Purpose: Shared constants and types for the receiver interrupt block
// Assumes: Two-byte register sub-address on the two-wire control bus
// Notes:   Crystal period is taken as a whole number of ref_clk cycles
package svi_pkg;

  // Register offsets
  localparam logic [15:0] OFS_CAPTURE_CFG  = 16'h1a69;
  localparam logic [15:0] OFS_LVL_CLR_A    = 16'h1a6a;
  localparam logic [15:0] OFS_LVL_CLR_B    = 16'h1a6b;
  localparam logic [15:0] OFS_LVL_PIN2_A   = 16'h1a6c;
  localparam logic [15:0] OFS_LVL_PIN2_B   = 16'h1a6d;
  localparam logic [15:0] OFS_EDGE_CLR_A   = 16'h1a70;
  localparam logic [15:0] OFS_EDGE_CLR_B   = 16'h1a71;

  // Field positions
  localparam int unsigned CFG_DUR_LSB      = 0;
  localparam int unsigned CFG_KEEP_BIT     = 2;
  localparam int unsigned LVL_A_MSB        = 5;
  localparam int unsigned EDGE_A_MSB       = 5;
  localparam int unsigned EDGE_B_LSB       = 6;

  // Reset values
  localparam logic [7:0]  RST_CAPTURE_CFG  = 8'h00;
  localparam logic [7:0]  RST_LVL_PIN2_A   = 8'h00;
  localparam logic [7:0]  RST_LVL_PIN2_B   = 8'h00;
  localparam logic [7:0]  RST_READ_ZERO    = 8'h00;

  // Pin pulse lengths in crystal periods
  localparam int unsigned PULSE_XTAL_SHORT = 4;
  localparam int unsigned PULSE_XTAL_MID   = 16;
  localparam int unsigned PULSE_XTAL_LONG  = 64;

  // Event counts
  localparam int unsigned LVL_N            = 14;
  localparam int unsigned EDGE_N           = 8;

  typedef enum logic [1:0] {
    SVI_DUR_SHORT = 2'b00,
    SVI_DUR_MID   = 2'b01,
    SVI_DUR_LONG  = 2'b10,
    SVI_DUR_HOLD  = 2'b11
  } svi_dur_e;

  typedef enum logic [2:0] {
    SVI_ST_IDLE   = 3'b000,
    SVI_ST_RX     = 3'b001,
    SVI_ST_RX_ACK = 3'b010,
    SVI_ST_TX     = 3'b011,
    SVI_ST_TX_ACK = 3'b100
  } svi_bus_state_e;

  typedef struct packed {
    logic cable_sense;
    logic link_pll_lock;
    logic link_clock_sense;
    logic stereo_video;
    logic av_silence;
    logic link_mode;
    logic general_ctrl_pkt;
    logic gamut_pkt;
    logic recording_code2;
    logic recording_code1;
    logic vendor_frame;
    logic media_frame;
    logic product_frame;
    logic video_info_frame;
  } svi_lvl_evt_s;

  typedef struct packed {
    logic vendor_frame_sum_err;
    logic media_frame_sum_err;
    logic product_frame_sum_err;
    logic video_frame_sum_err;
    logic colour_depth_change;
    logic link_clock_change;
    logic packet_fault;
    logic gamut_pkt_edge;
  } svi_edge_evt_s;

endpackage : svi_pkg

// *** design/svi_status_cell.sv ***
// Purpose: Vector of sticky interrupt status flags
// Assumes: Sources come from logic on ref_clk
// Notes:   A set in the same cycle as its clear wins
`timescale 1ns/1ps
`default_nettype none
module svi_status_cell
  import svi_pkg::*;
#(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] src,
  input  wire logic [WIDTH-1:0] clr,
  input  wire logic [WIDTH-1:0] cap_en,
  output logic      [WIDTH-1:0] status
);

  if (WIDTH < 1) begin : g_chk
    $error("svi_status_cell needs WIDTH of at least one");
  end

  logic [WIDTH-1:0] src_d_ff;
  logic [WIDTH-1:0] status_ff;
  logic             armed_ff;
  logic [WIDTH-1:0] trig;
  logic [WIDTH-1:0] nxt_status;

  // No trigger on the first cycle, the history is not yet valid
  assign trig       = (src ^ src_d_ff) & {WIDTH{armed_ff}};
  assign nxt_status = (status_ff & ~clr) | (trig & cap_en);
  assign status     = status_ff;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      src_d_ff  <= '0;
      status_ff <= '0;
      armed_ff  <= 1'b0;
    end else begin
      src_d_ff  <= src;
      status_ff <= nxt_status;
      armed_ff  <= 1'b1;
    end
  end

endmodule : svi_status_cell
`default_nettype wire

// *** verification/svi_irq_properties.sv ***
// Purpose: Port checks for the receiver interrupt block
// Assumes: Events, status and pin all on ref_clk
// Notes:   Set latency taken as one or two cycles after the change
`timescale 1ns/1ps
`default_nettype none
module svi_irq_properties
  import svi_pkg::*;
#(
  parameter logic [6:0]  DEV_ADDR = 7'h4c,
  parameter int unsigned XTAL_DIV = 1
) (
  input wire logic          ref_clk,
  input wire logic          rst_n,
  input wire logic          scl_in,
  input wire logic          sda_in,
  input wire logic          sda_out,
  input wire logic          sda_oe_n,
  input wire svi_lvl_evt_s  lvl_evt,
  input wire svi_edge_evt_s edge_evt,
  input wire svi_lvl_evt_s  lvl_status,
  input wire svi_edge_evt_s edge_status,
  input wire logic          second_irq_pin
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // First edge after reset only primes history
  sequence s_edge_chg;
    $past(rst_n) && (edge_evt != $past(edge_evt));
  endsequence
  sequence s_pin_up;
    $rose(second_irq_pin);
  endsequence

  property p_edge_cap;
    s_edge_chg |-> ##2 ((edge_status & ($past(edge_evt, 2)
      ^ $past(edge_evt, 3))) == ($past(edge_evt, 2) ^ $past(edge_evt, 3)));
  endproperty
  property p_edge_cause;
    ((edge_status & ~$past(edge_status)) & ~(($past(edge_evt)
      ^ $past(edge_evt, 2)) | ($past(edge_evt, 2) ^ $past(edge_evt, 3))))
      == 8'h00;
  endproperty
  property p_lvl_cause;
    ((lvl_status & ~$past(lvl_status)) & ~(($past(lvl_evt)
      ^ $past(lvl_evt, 2)) | ($past(lvl_evt, 2) ^ $past(lvl_evt, 3))))
      == 14'h0000;
  endproperty
  property p_pin_cause;
    s_pin_up |-> (lvl_status != 14'h0000);
  endproperty
  property p_pin_min;
    s_pin_up |-> second_irq_pin [*4];
  endproperty
  property p_sda_drive;
    sda_out == 1'b0;
  endproperty
  // Data may only move while the bus clock is low
  property p_sda_scl;
    $changed(sda_oe_n) |-> !scl_in;
  endproperty
  property p_sda_hold;
    $fell(sda_oe_n) |-> !sda_oe_n [*8];
  endproperty

  a_edge_cap: assert property (p_edge_cap)
    else $error("edge status missed a change");
  a_edge_cause: assert property (p_edge_cause)
    else $error("edge status set without a change");
  a_lvl_cause: assert property (p_lvl_cause)
    else $error("level status set without a change");
  a_pin_cause: assert property (p_pin_cause)
    else $error("pin rose with no level status");
  a_pin_min: assert property (p_pin_min)
    else $error("pin pulse shorter than four cycles");
  a_sda_drive: assert property (p_sda_drive)
    else $error("data pin value not low");
  a_sda_scl: assert property (p_sda_scl)
    else $error("data moved while bus clock high");
  a_sda_hold: assert property (p_sda_hold)
    else $error("data low held under one bit period");
endmodule : svi_irq_properties
`default_nettype wire

// *** verification/svi_host_model.sv ***
// Purpose: Two-wire bus master standing in for host software
// Assumes: Pull-up on the data wire is made by the bench
// Notes:   Phases of 8 cycles, twice the shortest allowed
`timescale 1ns/1ps
`default_nettype none
module svi_host_model
  import svi_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h4c
) (
  input  wire logic ref_clk,
  input  wire logic sda,
  output var logic  scl,
  output var logic  sda_low
);
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  task automatic tick;
    repeat (8) @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic bit_io(input logic b, output logic r);
    sda_low = ~b;
    tick();
    scl = 1'b1;
    tick();
    r   = sda;
    scl = 1'b0;
    tick();
  endtask : bit_io

  // Also serves as repeated start from clock low
  task automatic start;
    sda_low = 1'b0;
    tick();
    scl = 1'b1;
    tick();
    sda_low = 1'b1;
    tick();
    scl = 1'b0;
    tick();
  endtask : start

  task automatic stop;
    sda_low = 1'b1;
    tick();
    scl = 1'b1;
    tick();
    sda_low = 1'b0;
    tick();
  endtask : stop

  task automatic xfer(input logic [7:0] d, input logic ab,
                      output logic [7:0] r, output logic a);
    int i;
    for (i = 7; i >= 0; i--) bit_io(d[i], r[i]);
    bit_io(ab, a);
  endtask : xfer

  task automatic wr(input logic [15:0] ad, input logic [7:0] d,
                    output logic nak);
    logic [7:0] r;
    logic       a0, a1, a2, a3;
    start();
    xfer({DEV_ADDR, 1'b0}, 1'b1, r, a0);
    xfer(ad[15:8], 1'b1, r, a1);
    xfer(ad[7:0], 1'b1, r, a2);
    xfer(d, 1'b1, r, a3);
    stop();
    nak = a0 | a1 | a2 | a3;
  endtask : wr

  task automatic rd(input logic [15:0] ad, output logic [7:0] d,
                    output logic nak);
    logic [7:0] r;
    logic       a0, a1, a2, a3, dn;
    start();
    xfer({DEV_ADDR, 1'b0}, 1'b1, r, a0);
    xfer(ad[15:8], 1'b1, r, a1);
    xfer(ad[7:0], 1'b1, r, a2);
    start();
    xfer({DEV_ADDR, 1'b1}, 1'b1, r, a3);
    xfer(8'hff, 1'b1, d, dn);
    stop();
    nak = a0 | a1 | a2 | a3;
  endtask : rd
endmodule : svi_host_model
`default_nettype wire

// *** verification/svi_irq_ctrl_bench.sv ***
// Purpose: Self-checking bench for the receiver interrupt block
// Assumes: Registers reached only over the two-wire bus
// Notes:   Crystal divider of 2 so pulse lengths differ from codes
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("Error t=%0t got=%h exp=%h", $time, (g), (e)); end end
module svi_irq_ctrl_bench
  import svi_pkg::*;
;
  localparam int unsigned XD = 2;
  logic          ref_clk, rst_n, scl, host_low, sda_w, sda_out, sda_oe_n;
  logic          pin;
  svi_lvl_evt_s  lvl_evt, lvl_status;
  svi_edge_evt_s edge_evt, edge_status;
  logic [13:0]   exp_l;
  logic [7:0]    exp_e;
  int            fails, num_checks, i, w;
  int unsigned   lens [3] = '{PULSE_XTAL_SHORT, PULSE_XTAL_MID,
                              PULSE_XTAL_LONG};
  logic [15:0]   clr_ofs [4] = '{OFS_LVL_CLR_A, OFS_LVL_CLR_B,
                                 OFS_EDGE_CLR_A, OFS_EDGE_CLR_B};

  // Open drain wire with pull-up
  assign sda_w = (!sda_oe_n || host_low) ? 1'b0 : 1'b1;

  svi_irq_ctrl #(.XTAL_DIV(XD)) dut_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .lvl_evt(lvl_evt),
    .edge_evt(edge_evt), .lvl_status(lvl_status),
    .edge_status(edge_status), .second_irq_pin(pin));
  svi_host_model host_u (.ref_clk(ref_clk), .sda(sda_w), .scl(scl),
    .sda_low(host_low));

  initial ref_clk = 1'b0;
  always #2.5 ref_clk = ~ref_clk;

  task automatic regw(input logic [15:0] a, input logic [7:0] d);
    logic nak;
    host_u.wr(a, d, nak);
    `CHK(nak, 1'b0)
  endtask : regw

  task automatic regr(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] v;
    logic       nak;
    host_u.rd(a, v, nak);
    `CHK(v, e)
  endtask : regr

  task automatic ev(input logic [13:0] l, input logic [7:0] e);
    @(posedge ref_clk);
    #1;
    lvl_evt  = l;
    edge_evt = e;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask : ev

  // Flip sources, then time the pin pulse from its rise
  task automatic pulse(input logic [13:0] m, output int wd);
    int n;
    n  = 0;
    wd = 0;
    @(posedge ref_clk);
    #1;
    lvl_evt = lvl_evt ^ m;
    while (pin !== 1'b1 && n < 20) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    while (pin === 1'b1 && wd < 300) begin
      @(posedge ref_clk);
      #1;
      wd++;
    end
  endtask : pulse

  task automatic close_out;
    $display("checks=%0d errors=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out

  initial begin
    repeat (70000) @(posedge ref_clk);
    fails++;
    close_out();
  end

  initial begin
    lvl_evt    = '0;
    edge_evt   = '0;
    rst_n      = 1'b0;
    fails      = 0;
    num_checks = 0;
    repeat (3) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    regr(OFS_CAPTURE_CFG, RST_CAPTURE_CFG);
    regr(OFS_LVL_PIN2_A, RST_LVL_PIN2_A);
    regr(OFS_LVL_PIN2_B, RST_LVL_PIN2_B);
    regr(OFS_LVL_CLR_A, RST_READ_ZERO);
    regr(16'h1a60, 8'h00);
    regw(OFS_LVL_PIN2_A, 8'h3f);
    regr(OFS_LVL_PIN2_A, 8'h3f);
    regw(OFS_LVL_PIN2_B, 8'ha5);
    regr(OFS_LVL_PIN2_B, 8'ha5);
    regw(OFS_LVL_PIN2_A, 8'h00);
    regw(OFS_LVL_PIN2_B, 8'h00);
    ev(14'h3fff, 8'h00);
    `CHK(lvl_status, 14'h0000)
    regw(OFS_CAPTURE_CFG, 8'h04);
    regr(OFS_CAPTURE_CFG, 8'h04);
    ev(14'h0000, 8'hff);
    `CHK(lvl_status, 14'h3fff)
    `CHK(pin, 1'b0)
    `CHK(edge_status, 8'hff)
    for (i = 0; i < 4; i++) regw(clr_ofs[i], 8'h00);
    `CHK(lvl_status, 14'h3fff)
    `CHK(edge_status, 8'hff)
    exp_l = 14'h3fff;
    for (i = 13; i >= 0; i--) begin
      exp_l[i] = 1'b0;
      if (i > 7) regw(OFS_LVL_CLR_A, 8'h01 << (i - 8));
      else regw(OFS_LVL_CLR_B, 8'h01 << i);
      `CHK(lvl_status, exp_l)
    end
    exp_e = 8'hff;
    for (i = 7; i >= 0; i--) begin
      exp_e[i] = 1'b0;
      if (i > 1) regw(OFS_EDGE_CLR_A, 8'h01 << (i - 2));
      else regw(OFS_EDGE_CLR_B, 8'h40 << i);
      `CHK(edge_status, exp_e)
    end
    regr(OFS_EDGE_CLR_B, 8'h00);
    regw(OFS_LVL_PIN2_A, 8'h3f);
    regw(OFS_LVL_PIN2_B, 8'hff);
    for (i = 0; i < 3; i++) begin
      regw(OFS_CAPTURE_CFG, 8'(i));
      pulse(14'h2000 >> (6 * i), w);
      `CHK(w, int'(lens[i] * XD))
      regw(OFS_LVL_CLR_A, 8'h3f);
      regw(OFS_LVL_CLR_B, 8'hff);
    end
    regw(OFS_CAPTURE_CFG, 8'h03);
    pulse(14'h0001, w);
    `CHK(w, 300)
    regw(OFS_LVL_CLR_B, 8'h01);
    `CHK(pin, 1'b0)
    close_out();
  end
endmodule : svi_irq_ctrl_bench

bind svi_irq_ctrl svi_irq_properties #(
  .DEV_ADDR(DEV_ADDR),
  .XTAL_DIV(XTAL_DIV)
) chk_u (
  .ref_clk(ref_clk), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n), .lvl_evt(lvl_evt),
  .edge_evt(edge_evt), .lvl_status(lvl_status),
  .edge_status(edge_status), .second_irq_pin(second_irq_pin)
);
`default_nettype wire
